//--- rtl/lcc_pkg.sv
// shared constants and carrier types for the logic cell cluster
package lcc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // cluster shape
   localparam int unsigned NCELL = 10;
   localparam int unsigned REGEN_CELL = 5;
   localparam int unsigned NOUT = 3;
   localparam int unsigned NDATA = 4;

   ////////////////////////////////////////////////////////////////////////////
   // avalon register map, word addresses
   localparam logic [3:0] ADR_CFG_LAST = 4'h9;
   localparam logic [3:0] ADR_STATUS = 4'ha;
   localparam int unsigned CFG_W = 27;
   localparam int unsigned STATUS_PAD = 22;
   localparam int unsigned CFG_PAD = 5;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // storage element behaviour
   typedef enum logic [1:0] {
      LCC_FF_D = 2'h0,
      LCC_FF_T = 2'h1,
      LCC_FF_JK = 2'h2,
      LCC_FF_SR = 2'h3
   } lcc_ff_type;

   // per-cell configuration word, msb first
   typedef struct packed {
      logic counter;
      logic lut_chain;
      logic reg_chain;
      logic pack_fb;
      logic carry_tbl;
      logic [2:0] out_sel;
      lcc_ff_type ff;
      logic arith;
      logic [15:0] mask;
   } lcc_cfg_type;

   localparam lcc_cfg_type CFG_RESET = 27'h000_0000;

   // cluster-wide control signals
   typedef struct packed {
      logic clk_ena;
      logic aclr;
      logic aload;
      logic sclr;
      logic sload;
      logic add_nsub;
   } lcc_ctrl_type;

endpackage

//--- rtl/lcc_cell_cluster.sv
// ten-cell logic cluster with carry-select chain and avalon configuration port
//
// How it works
// - each cell's table computes any function of four inputs from a mask
// - storage element behaves as d, t, jk or sr flip-flop per cell
// - register has data, load data, clock, enable, clear and load/preset controls
// - asynchronous load takes its value from the cell's fourth data input
// - table result can reach outputs without passing the cell register
// - three general outputs per cell, each from table or register
// - packing option feeds register output back into own table
// - registered and unregistered table result may appear together
// - table chain and register chain pass results to the next cell
// - subtraction inverts every b bit and forces carry in to one
// - each cell is in normal or arithmetic mode, routing inputs differently
// - each cell takes four data, two chain carries, cluster carry, register chain
// - cluster controls steer every register; add/subtract applies in arithmetic
// - normal mode feeds the table, carry or fourth input as one input
// - arithmetic mode forms one sum and two carries per cell from a and b, not from the mask
// - cluster carry picks a chain, whose level picks the sum
// - both chain carry outputs repeat the final carry chosen by cluster carry
// - arithmetic mode counts with enable and direction from data inputs
// - synchronous clear and load act on all cluster registers at once
// - chains start only at the first cell; cluster carry regenerates once, after the fifth cell
// - chain continues to next cluster; final carry leaves on carry_o
// - cluster holds ten cells sharing controls and carry chain
// - asynchronous clear beats asynchronous load when both are high
// - low clock enable holds every cell register except under async clear or load
`timescale 1ns/10ps
module lcc_cell_cluster (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // cluster control and neighbour inputs
   input wire lcc_pkg::lcc_ctrl_type ctrl_i,
   input wire logic [lcc_pkg::NCELL-1:0][lcc_pkg::NDATA-1:0] cell_data_i,
   input wire logic cluster_carry_i,
   input wire logic zero_assumed_carry_chain_in_i,
   input wire logic one_assumed_carry_chain_in_i,
   input wire logic reg_chain_i,
   // cell outputs
   output logic [lcc_pkg::NCELL-1:0][lcc_pkg::NOUT-1:0] general_o,
   output logic table_chain_o,
   output logic reg_chain_o,
   output logic zero_assumed_carry_chain_out_o,
   output logic one_assumed_carry_chain_out_o,
   output logic carry_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      lcc_pkg::lcc_cfg_type [lcc_pkg::NCELL-1:0] cfg;
      logic [lcc_pkg::NCELL-1:0] q;
      logic [lcc_pkg::NCELL-1:0][lcc_pkg::NOUT-1:0] gen;
      logic tchain;
      logic rchain;
      logic c0_out;
      logic c1_out;
      logic cout;
      logic waitreq;
      logic [31:0] rdata;
   } lcc_state_type;

   lcc_state_type r_q;
   lcc_state_type r_d;

   logic [lcc_pkg::NCELL-1:0] tbl;
   logic [lcc_pkg::NCELL-1:0] cin_v;
   logic [lcc_pkg::NCELL-1:0] d3_v;
   logic first_cin;
   logic c0;
   logic c1;
   logic sel;
   logic a;
   logic b;
   logic src;
   logic prev_tbl;
   logic prev_q;
   logic k;
   logic ff_next;
   logic [3:0] idx;
   logic accept;
   logic done;
   logic [31:0] word;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      r_d = r_q;
      tbl = '0;
      cin_v = '0;
      d3_v = '0;
      c0 = zero_assumed_carry_chain_in_i;
      c1 = one_assumed_carry_chain_in_i;
      sel = cluster_carry_i;
      a = 1'b0;
      b = 1'b0;
      src = 1'b0;
      k = 1'b0;
      ff_next = 1'b0;
      idx = 4'h0;
      prev_tbl = 1'b0;
      prev_q = reg_chain_i;
      word = 32'h0000_0000;
      first_cin = 1'b0;
      accept = (avs_read_i | avs_write_i) & r_q.waitreq;
      done = (avs_read_i | avs_write_i) & ~r_q.waitreq;

      // first cell of an arithmetic chain: forced carry
      if (r_q.cfg[0].arith && r_q.cfg[0].counter) begin
         c0 = cell_data_i[0][3];
         c1 = cell_data_i[0][3];
      end else if (r_q.cfg[0].arith && !ctrl_i.add_nsub) begin
         c0 = 1'b1;
         c1 = 1'b1;
      end
      first_cin = sel ? c1 : c0;

      for (int i = 0; i < lcc_pkg::NCELL; i++) begin
         // cluster carry regenerated mid-cluster to keep the critical path short
         if (i == lcc_pkg::REGEN_CELL) begin
            sel = sel ? c1 : c0;
            c0 = 1'b0;
            c1 = 1'b1;
         end
         cin_v[i] = sel ? c1 : c0;
         d3_v[i] = cell_data_i[i][3];
         if (r_q.cfg[i].arith) begin
            a = r_q.cfg[i].counter ? r_q.q[i] : cell_data_i[i][1];
            b = r_q.cfg[i].counter ? ~cell_data_i[i][3] : (cell_data_i[i][2] ^ ~ctrl_i.add_nsub);
            tbl[i] = a ^ b ^ cin_v[i];
            c0 = c0 ? (a | b) : (a & b);
            c1 = c1 ? (a | b) : (a & b);
         end else begin
            idx[0] = r_q.cfg[i].lut_chain ? prev_tbl : cell_data_i[i][0];
            idx[1] = cell_data_i[i][1];
            idx[2] = r_q.cfg[i].pack_fb ? r_q.q[i] : cell_data_i[i][2];
            idx[3] = r_q.cfg[i].carry_tbl ? cin_v[i] : cell_data_i[i][3];
            tbl[i] = r_q.cfg[i].mask[idx];
         end
         prev_tbl = tbl[i];

         // storage element
         src = r_q.cfg[i].reg_chain ? prev_q : tbl[i];
         k = cell_data_i[i][2];
         case (r_q.cfg[i].ff)
            lcc_pkg::LCC_FF_D: ff_next = src;
            lcc_pkg::LCC_FF_T: ff_next = r_q.q[i] ^ src;
            lcc_pkg::LCC_FF_JK: ff_next = (src & ~r_q.q[i]) | (~k & r_q.q[i]);
            lcc_pkg::LCC_FF_SR: ff_next = k ? 1'b0 : (src | r_q.q[i]);
            default: ff_next = src;
         endcase
         prev_q = r_q.q[i];

         // priority: each clear beats its own load, async beats enable and sync
         if (ctrl_i.aclr) begin
            r_d.q[i] = 1'b0;
         end else if (ctrl_i.aload) begin
            r_d.q[i] = cell_data_i[i][3];
         end else if (!ctrl_i.clk_ena) begin
            r_d.q[i] = r_q.q[i];
         end else if (ctrl_i.sclr) begin
            r_d.q[i] = 1'b0;
         end else if (ctrl_i.sload) begin
            r_d.q[i] = cell_data_i[i][3];
         end else if (r_q.cfg[i].arith && r_q.cfg[i].counter) begin
            r_d.q[i] = cell_data_i[i][0] ? tbl[i] : r_q.q[i];
         end else begin
            r_d.q[i] = ff_next;
         end

         // general outputs: register or bypassed table
         for (int j = 0; j < lcc_pkg::NOUT; j++) begin
            r_d.gen[i][j] = r_q.cfg[i].out_sel[j] ? r_q.q[i] : tbl[i];
         end
      end

      // chain leaves the cluster after the tenth cell
      r_d.tchain = tbl[lcc_pkg::NCELL-1];
      r_d.rchain = r_q.q[lcc_pkg::NCELL-1];
      r_d.cout = sel ? c1 : c0;
      r_d.c0_out = r_d.cout;
      r_d.c1_out = r_d.cout;

      ////////////////////////////////////////////////////////////////////////////
      // avalon slave: one wait cycle, then the access completes
      r_d.waitreq = ~accept;
      if (accept) begin
         if (avs_read_i && avs_address_i <= lcc_pkg::ADR_CFG_LAST) begin
            r_d.rdata = {{lcc_pkg::CFG_PAD{1'b0}}, r_q.cfg[avs_address_i]};
         end else if (avs_read_i && avs_address_i == lcc_pkg::ADR_STATUS) begin
            r_d.rdata = {{lcc_pkg::STATUS_PAD{1'b0}}, r_q.q};
         end else begin
            r_d.rdata = lcc_pkg::RDATA_UNMAPPED;
         end
      end
      if (done && avs_write_i && avs_address_i <= lcc_pkg::ADR_CFG_LAST) begin
         word = {{lcc_pkg::CFG_PAD{1'b0}}, r_q.cfg[avs_address_i]};
         for (int l = 0; l < 4; l++) begin
            if (avs_byteenable_i[l]) begin
               word[l*8 +: 8] = avs_writedata_i[l*8 +: 8];
            end
         end
         r_d.cfg[avs_address_i] = word[lcc_pkg::CFG_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         r_q <= '0;
         r_q.cfg <= {lcc_pkg::NCELL{lcc_pkg::CFG_RESET}};
         r_q.waitreq <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign avs_readdata_o = r_q.rdata;
   assign avs_waitrequest_o = r_q.waitreq;
   assign general_o = r_q.gen;
   assign table_chain_o = r_q.tchain;
   assign reg_chain_o = r_q.rchain;
   assign zero_assumed_carry_chain_out_o = r_q.c0_out;
   assign one_assumed_carry_chain_out_o = r_q.c1_out;
   assign carry_o = r_q.cout;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   chk_aclr_wins: assert property (ctrl_i.aclr |=> r_q.q == '0)
      else $error("async clear did not zero registers");

   chk_aload_data: assert property (!ctrl_i.aclr && ctrl_i.aload |=> r_q.q == $past(d3_v))
      else $error("async load did not take fourth data input");

   chk_ena_hold: assert property (!ctrl_i.aclr && !ctrl_i.aload && !ctrl_i.clk_ena |=> $stable(r_q.q))
      else $error("registers moved with clock enable low");

   chk_sclr_first: assert property (
      !ctrl_i.aclr && !ctrl_i.aload && ctrl_i.clk_ena && ctrl_i.sclr |=> r_q.q == '0)
      else $error("sync clear lost to sync load");

   chk_sload_all: assert property (
      !ctrl_i.aclr && !ctrl_i.aload && ctrl_i.clk_ena && !ctrl_i.sclr && ctrl_i.sload
      |=> r_q.q == $past(d3_v))
      else $error("sync load missed a register");

   chk_sub_carry: assert property (
      r_q.cfg[0].arith && !r_q.cfg[0].counter && !ctrl_i.add_nsub |-> first_cin)
      else $error("subtract did not force carry in");

   chk_arith_sum: assert property (
      r_q.cfg[0].arith && !r_q.cfg[0].counter
      |-> tbl[0] == (cell_data_i[0][1] ^ cell_data_i[0][2] ^ ~ctrl_i.add_nsub ^ first_cin))
      else $error("cell zero sum mismatch");

   chk_out_route: assert property (
      r_q.cfg[3].out_sel[1] |=> general_o[3][1] == $past(r_q.q[3]))
      else $error("general output not from register");

   chk_bus_wait: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest not a single low cycle");

   chk_regen_mid: assert property (
      r_q.cfg[4].arith && !r_q.cfg[4].counter && r_q.cfg[5].arith
      |-> cin_v[lcc_pkg::REGEN_CELL] == ((cell_data_i[4][1] & (cell_data_i[4][2] ^ ~ctrl_i.add_nsub))
      | (cin_v[4] & (cell_data_i[4][1] ^ cell_data_i[4][2] ^ ~ctrl_i.add_nsub))))
      else $error("regenerated carry lost the chain");

   ////////////////////////////////////////////////////////////////////////////
   // cell-level checks; all but the async clear, async load and chain output checks look at one cell to keep the property set small
   logic ff_free;
   assign ff_free = ctrl_i.clk_ena & ~ctrl_i.aclr & ~ctrl_i.aload & ~ctrl_i.sclr & ~ctrl_i.sload;

   chk_aclr_no_ena: assert property (
      ctrl_i.aclr && !ctrl_i.clk_ena
      |=> r_q.q == '0)
      else $error("async clear waited for clock enable");

   chk_aload_no_ena: assert property (
      !ctrl_i.aclr && ctrl_i.aload && !ctrl_i.clk_ena
      |=> r_q.q == $past(d3_v))
      else $error("async load waited for clock enable");

   chk_norm_table: assert property (
      !r_q.cfg[1].arith && !r_q.cfg[1].lut_chain && !r_q.cfg[1].pack_fb && !r_q.cfg[1].carry_tbl
      |-> tbl[1] == r_q.cfg[1].mask[cell_data_i[1]])
      else $error("table output not the mask entry");

   chk_carry_input: assert property (
      !r_q.cfg[1].arith && r_q.cfg[1].carry_tbl && !r_q.cfg[1].lut_chain && !r_q.cfg[1].pack_fb
      |-> tbl[1] == r_q.cfg[1].mask[{cin_v[1], cell_data_i[1][2:0]}])
      else $error("carry not used as table input");

   chk_lut_chain: assert property (
      !r_q.cfg[2].arith && r_q.cfg[2].lut_chain && !r_q.cfg[2].pack_fb && !r_q.cfg[2].carry_tbl
      |-> tbl[2] == r_q.cfg[2].mask[{cell_data_i[2][3:1], tbl[1]}])
      else $error("table chain input not used");

   chk_pack_fb: assert property (
      !r_q.cfg[2].arith && r_q.cfg[2].pack_fb && !r_q.cfg[2].lut_chain && !r_q.cfg[2].carry_tbl
      |-> tbl[2] == r_q.cfg[2].mask[{cell_data_i[2][3], r_q.q[2], cell_data_i[2][1:0]}])
      else $error("packed register not fed back");

   chk_tff_toggle: assert property (
      ff_free && r_q.cfg[1].ff == lcc_pkg::LCC_FF_T && !r_q.cfg[1].reg_chain && !r_q.cfg[1].counter
      |=> r_q.q[1] == ($past(r_q.q[1]) ^ $past(tbl[1])))
      else $error("t flip-flop did not toggle");

   chk_shift_step: assert property (
      ff_free && r_q.cfg[3].reg_chain && r_q.cfg[3].ff == lcc_pkg::LCC_FF_D && !r_q.cfg[3].counter
      |=> r_q.q[3] == $past(r_q.q[2]))
      else $error("register chain did not shift");

   chk_rchain_out: assert property (
      1'b1 |=> reg_chain_o == $past(r_q.q[lcc_pkg::NCELL-1]))
      else $error("register chain output wrong");

   chk_tchain_out: assert property (
      1'b1 |=> table_chain_o == $past(tbl[lcc_pkg::NCELL-1]))
      else $error("table chain output wrong");

   // lsb of a counter flips on every enabled step, whatever the direction
   chk_count_step: assert property (
      ff_free && r_q.cfg[0].arith && r_q.cfg[0].counter && cell_data_i[0][0]
      |=> r_q.q[0] != $past(r_q.q[0]))
      else $error("counter did not step");

   chk_count_idle: assert property (
      ff_free && r_q.cfg[0].arith && r_q.cfg[0].counter && !cell_data_i[0][0]
      |=> $stable(r_q.q[0]))
      else $error("counter moved without enable");

   chk_gen_table: assert property (
      !r_q.cfg[4].out_sel[0]
      |=> general_o[4][0] == $past(tbl[4]))
      else $error("general output not from table");

   chk_both_copies: assert property (
      r_q.cfg[4].out_sel == 3'h2
      |=> general_o[4][1] == $past(r_q.q[4])
      && general_o[4][0] == $past(tbl[4]))
      else $error("registered and table copies not both shown");

   chk_sub_invert: assert property (
      r_q.cfg[1].arith && !r_q.cfg[1].counter && !ctrl_i.add_nsub
      |-> tbl[1] == (cell_data_i[1][1] ^ ~cell_data_i[1][2] ^ cin_v[1]))
      else $error("subtract did not invert b");

   ////////////////////////////////////////////////////////////////////////////
   // bus-side checks
   chk_status_read: assert property (
      avs_read_i && avs_waitrequest_o && avs_address_i == lcc_pkg::ADR_STATUS
      |=> avs_readdata_o == {{lcc_pkg::STATUS_PAD{1'b0}}, $past(r_q.q)})
      else $error("status read wrong");

   chk_unmapped_zero: assert property (
      avs_read_i && avs_waitrequest_o && avs_address_i > lcc_pkg::ADR_STATUS
      |=> avs_readdata_o == lcc_pkg::RDATA_UNMAPPED)
      else $error("unmapped read not zero");

   chk_cfg_pad: assert property (
      avs_read_i && avs_waitrequest_o && avs_address_i <= lcc_pkg::ADR_CFG_LAST
      |=> avs_readdata_o[31:lcc_pkg::CFG_W] == '0)
      else $error("config read upper bits not zero");

   chk_cfg_write: assert property (
      avs_write_i && !avs_waitrequest_o && avs_address_i <= lcc_pkg::ADR_CFG_LAST && &avs_byteenable_i
      |=> r_q.cfg[$past(avs_address_i)] == $past(avs_writedata_i[lcc_pkg::CFG_W-1:0]))
      else $error("config write lost");

   // idle bus must never see a stray low waitrequest
   chk_wait_idle: assert property (
      !avs_read_i && !avs_write_i
      |=> avs_waitrequest_o)
      else $error("waitrequest low without a request");

   cov_subtract: cover property (r_q.cfg[0].arith && !ctrl_i.add_nsub ##1 r_q.q != '0);
   cov_count: cover property (r_q.cfg[0].counter && cell_data_i[0][0] && ctrl_i.clk_ena ##1 r_q.q[0]);
   cov_aload: cover property (ctrl_i.aload && !ctrl_i.aclr);
   cov_write: cover property (avs_write_i && !avs_waitrequest_o);
   cov_route: cover property (r_q.cfg[2].lut_chain && tbl[2]);

endmodule

//--- test/lcc_neighbour_model.sv
// neighbour cells and cluster control generator model
`timescale 1ns/10ps
module lcc_neighbour_model (
   // clock
   input wire logic clk_sys_i,
   // toward the cluster
   output lcc_pkg::lcc_ctrl_type ctrl_o,
   output logic carry_o,
   output logic chain0_o,
   output logic chain1_o,
   output logic reg_chain_o
);
   // no lower cluster: chains sit at their assumed levels
   initial begin
      ctrl_o = 6'h00;
      carry_o = 1'b0;
      chain0_o = 1'b0;
      chain1_o = 1'b1;
      reg_chain_o = 1'b0;
   end
   // levels move only by nba just after an edge
   task automatic drive(input lcc_pkg::lcc_ctrl_type c, input logic cin, input logic sh);
      ctrl_o <= c;
      carry_o <= cin;
      reg_chain_o <= sh;
   endtask
endmodule

//--- test/lcc_cell_cluster_bench.sv
// self-checking bench for the logic cell cluster
`timescale 1ns/10ps
module lcc_cell_cluster_bench;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   lcc_pkg::lcc_ctrl_type ctrl;
   logic [lcc_pkg::NCELL-1:0][lcc_pkg::NDATA-1:0] cell_data_i = '0;
   logic cin, ch0, ch1, shin, tch, rch, c0, c1, cy;
   logic [lcc_pkg::NCELL-1:0][lcc_pkg::NOUT-1:0] general_o;
   logic [31:0] rd;
   lcc_pkg::lcc_cfg_type cf;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   lcc_cell_cluster dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .ctrl_i(ctrl), .cell_data_i(cell_data_i), .cluster_carry_i(cin), .zero_assumed_carry_chain_in_i(ch0),
      .one_assumed_carry_chain_in_i(ch1), .reg_chain_i(shin), .general_o(general_o), .table_chain_o(tch),
      .reg_chain_o(rch), .zero_assumed_carry_chain_out_o(c0), .one_assumed_carry_chain_out_o(c1), .carry_o(cy));
   lcc_neighbour_model nb_u (.clk_sys_i(clk_sys_i), .ctrl_o(ctrl), .carry_o(cin), .chain0_o(ch0),
      .chain1_o(ch1), .reg_chain_o(shin));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // avalon access: hold until waitrequest seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= wd;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      chk(32'(avs_waitrequest_o), 32'h0);
   endtask
   task automatic cfg_all(input lcc_pkg::lcc_cfg_type c);
      for (int i = 0; i < lcc_pkg::NCELL; i++)
         bus(1'b1, 4'(i), 32'(c));
   endtask
   // status reads only with clock enable low, so registers hold meanwhile
   task automatic st(input logic [9:0] e);
      bus(1'b0, lcc_pkg::ADR_STATUS, 32'h0);
      chk(rd, {22'h0, e});
   endtask
   task automatic pulse(input logic [5:0] c, input int n);
      @(posedge clk_sys_i);
      nb_u.drive(c, 1'b0, 1'b0);
      repeat (n) @(posedge clk_sys_i);
      nb_u.drive(6'h00, 1'b0, 1'b0);
   endtask
   task automatic t_regs();
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 4'h9, 32'hffff_ffff);
      bus(1'b0, 4'h9, 32'h0);
      chk(rd, 32'h07ff_ffff);
      bus(1'b0, 4'hf, 32'h0);
      chk(rd, 32'h0);
   endtask
   // output 1 from the register (still zero), outputs 0 and 2 from the table
   task automatic t_lut();
      cf = '0;
      cf.mask = 16'h6996;
      cf.out_sel = 3'h2;
      cfg_all(cf);
      for (int v = 0; v < 16; v++) begin
         @(posedge clk_sys_i);
         cell_data_i[0] <= 4'(v);
         @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         chk(32'(general_o[0]), {29'h0, ^4'(v), 1'b0, ^4'(v)});
      end
   endtask
   task automatic t_ctl();
      cell_data_i <= {lcc_pkg::NCELL{4'h8}};
      pulse(6'h08, 1);
      st(10'h3ff);
      pulse(6'h18, 1);
      st(10'h000);
      pulse(6'h22, 1);
      st(10'h3ff);
      pulse(6'h06, 1);
      st(10'h3ff);
      pulse(6'h26, 1);
      st(10'h000);
      cf = '0;
      cf.mask = 16'hffff;
      cf.ff = lcc_pkg::LCC_FF_T;
      cfg_all(cf);
      pulse(6'h20, 3);
      st(10'h3ff);
      chk(32'({tch, rch}), 32'h3);
   endtask
   task automatic add(input logic [9:0] a, input logic [9:0] b, input logic sub, input logic ci);
      logic [10:0] e;
      logic [9:0] s;
      @(posedge clk_sys_i);
      for (int i = 0; i < lcc_pkg::NCELL; i++)
         cell_data_i[i] <= {1'b0, b[i], a[i], 1'b0};
      nb_u.drive({5'h00, ~sub}, ci, 1'b0);
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      e = {1'b0, a} + {1'b0, sub ? ~b : b} + 11'(sub | ci);
      for (int i = 0; i < lcc_pkg::NCELL; i++)
         s[i] = general_o[i][0];
      chk({19'h0, c1, c0, cy, s}, {19'h0, {3{e[10]}}, e[9:0]});
   endtask
   task automatic t_count();
      cf = '0;
      cf.arith = 1'b1;
      cfg_all(cf);
      add(10'h3ff, 10'h001, 1'b0, 1'b0);
      add(10'h0ff, 10'h100, 1'b0, 1'b1);
      add(10'h005, 10'h007, 1'b1, 1'b1);
      add(10'h200, 10'h0ff, 1'b1, 1'b0);
      cf.counter = 1'b1;
      cf.out_sel = 3'h7;
      cfg_all(cf);
      pulse(6'h24, 1);
      cell_data_i <= {lcc_pkg::NCELL{4'h9}};
      pulse(6'h20, 3);
      st(10'h003);
      cell_data_i <= {lcc_pkg::NCELL{4'h1}};
      pulse(6'h20, 5);
      st(10'h3fe);
      cell_data_i <= {lcc_pkg::NCELL{4'h8}};
      pulse(6'h20, 2);
      st(10'h3fe);
   endtask
   // counter leaves 3fe behind: clear first so the shifted pattern is known
   task automatic t_shift();
      cf = '0;
      cf.reg_chain = 1'b1;
      cfg_all(cf);
      pulse(6'h24, 1);
      @(posedge clk_sys_i);
      nb_u.drive(6'h20, 1'b0, 1'b1);
      @(posedge clk_sys_i);
      nb_u.drive(6'h20, 1'b0, 1'b0);
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      nb_u.drive(6'h00, 1'b0, 1'b0);
      st(10'h004);
   endtask
   // table-input options; registers hold 004 from the shift test
   task automatic t_route();
      cf = '0;
      cf.lut_chain = 1'b1;
      cf.mask = 16'h5555;
      cfg_all(cf);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(32'(general_o), 32'h071c_71c7);
      @(posedge clk_sys_i);
      nb_u.drive(6'h00, 1'b1, 1'b0);
      cf = '0;
      cf.carry_tbl = 1'b1;
      cf.mask = 16'hff00;
      cfg_all(cf);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(32'(general_o), 32'h3fff_ffff);
      @(posedge clk_sys_i);
      nb_u.drive(6'h00, 1'b0, 1'b0);
      cf = '0;
      cf.pack_fb = 1'b1;
      cf.mask = 16'hf0f0;
      cfg_all(cf);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(32'(general_o), 32'h0000_01c0);
   endtask

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_regs();
      t_lut();
      t_ctl();
      t_count();
      t_shift();
      t_route();
      test_done();
   end
endmodule
